// >>> rtcbcd_params.svh
// Purpose: Constants of the BCD time and weekday counter block
// Assumes: APB byte addresses, 32-bit data, 250 MHz pclk
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef RTCBCD_PARAMS_SVH
`define RTCBCD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTC_OFS_SEC    8'h00
`define RTC_OFS_MIN    8'h04
`define RTC_OFS_HOUR   8'h08
`define RTC_OFS_WDAY   8'h0C
`define RTC_OFS_CTRL1  8'h10
`define RTC_OFS_CTRL2  8'h14
`define RTC_OFS_ISTAT  8'h18
`define RTC_OFS_IMASK  8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTC_C1_START   7
`define RTC_C1_FMT24   6
`define RTC_C1_PM      5
`define RTC_C1_SRST    4
`define RTC_C1_BUSY    1
`define RTC_C2_SECIE   0

// ----------------------------------------------------------------
// Count limits and reset values
// ----------------------------------------------------------------
`define RTC_UNITS_LAST 4'h9
`define RTC_TENS_LAST  4'h5
`define RTC_H24_LAST   7'h23
`define RTC_H12_LAST   7'h11
`define RTC_DAY_LAST   3'h6
`define RTC_RST_TIME   7'h00
`define RTC_RST_DAY    3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTC_SEC_PERIOD_NS 1000000000
`define RTC_CLK_PERIOD_NS 4
`define RTC_TICK_CYCLES   (`RTC_SEC_PERIOD_NS / `RTC_CLK_PERIOD_NS)

`endif

// >>> rtcbcd_pkg.sv
// Purpose: Types of the BCD time and weekday counter block
// Assumes: Nothing beyond the params header
// Notes:   Types only, constants live in the header
`default_nettype none
package rtcbcd_pkg;
    typedef logic [6:0] rtcbcd_time_t;   // Two BCD digits, bit 7 absent
    typedef logic [3:0] rtcbcd_digit_t;  // One BCD digit
    typedef logic [2:0] rtcbcd_day_t;    // Weekday code
endpackage
`default_nettype wire

// >>> rtcbcd_tb_top.sv
// Purpose: Self-checking bench for the BCD time and weekday counters
// Assumes: APB slave may add wait states, TICK_CYCLES shortened to keep runs short
// Notes:   Counting is stopped after each tick so reads see a frozen time
`timescale 1ns/1ps
`default_nettype none
`include "rtcbcd_params.svh"

module rtcbcd_tb_top;
    // ------------------------------------------------------------
    // Signals and clock
    // ------------------------------------------------------------
    localparam int TICK = 40;  // Long enough that stopping beats the next tick
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    logic [31:0] r;
    logic        e;
    logic [31:0] c1_run     = 32'h000000C0;  // Control 1 value that starts a tick run
    logic [31:0] c1_exp     = 32'h000000C2;  // Control 1 read back after the tick, busy set

    // 250 MHz clock
    initial
    begin
        forever #2 pclk = ~pclk;
    end

    rtcbcd_top #(.TICK_CYCLES(TICK)) dut_u (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict and the single end of the run
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; ready, data and error are taken at the closing rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                n_mismatch++;
                wrap_up();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h00000000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h00000000);
    endtask

    // Preset a time, let one tick pass, freeze and read the result back
    task automatic run_tick(input logic [31:0] s, input logic [31:0] m, input logic [31:0] h,
                            input logic [31:0] d, input logic [31:0] es,
                            input logic [31:0] em, input logic [31:0] eh,
                            input logic [31:0] ed);
        int n;
        n = 0;
        wr(`RTC_OFS_SEC, s);
        wr(`RTC_OFS_MIN, m);
        wr(`RTC_OFS_HOUR, h);
        wr(`RTC_OFS_WDAY, d);  // Callers never pass code 7
        wr(`RTC_OFS_CTRL1, c1_run);  // Start, 24-hour unless a scenario changes it
        @(negedge pclk);
        while (irq !== 1'b1)
        begin
            n++;
            if (n > 4 * TICK)
            begin
                n_mismatch++;
                wrap_up();
            end
            @(negedge pclk);
        end
        rd_chk(`RTC_OFS_CTRL1, c1_exp);
        wr(`RTC_OFS_CTRL1, 32'h00000040);
        rd_chk(`RTC_OFS_SEC, es);
        rd_chk(`RTC_OFS_MIN, em);
        rd_chk(`RTC_OFS_HOUR, eh);
        rd_chk(`RTC_OFS_WDAY, ed);
        rd_chk(`RTC_OFS_ISTAT, 32'h00000001);
        rd_chk(`RTC_OFS_ISTAT, 32'h00000000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    // Hang guard well beyond the length of the run
    initial
    begin
        #40000;
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // All registers clear after reset
        for (int i = 0; i < 8; i++)
            rd_chk(8'(i * 4), 32'h00000000);
        // Bit 7 is dropped on write and reads zero
        wr(`RTC_OFS_SEC, 32'h000000A5);
        rd_chk(`RTC_OFS_SEC, 32'h00000025);
        wr(`RTC_OFS_MIN, 32'h000000D9);
        rd_chk(`RTC_OFS_MIN, 32'h00000059);
        wr(`RTC_OFS_HOUR, 32'h00000092);
        rd_chk(`RTC_OFS_HOUR, 32'h00000012);
        // Every legal weekday code, never 7
        for (int d = 0; d < 7; d++)
        begin
            wr(`RTC_OFS_WDAY, 32'(d));
            rd_chk(`RTC_OFS_WDAY, 32'(d));
        end
        // Unmapped address is refused and reads zero
        apb(1'b1, 8'h20, 32'h000000FF, r, e);
        chk({31'h0, e}, 32'h00000001);
        apb(1'b0, 8'h20, 32'h00000000, r, e);
        chk(r, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        // Carry chain, one boundary per digit
        wr(`RTC_OFS_CTRL2, 32'h00000001);
        wr(`RTC_OFS_IMASK, 32'h00000001);
        run_tick(32'h09, 32'h00, 32'h00, 32'h0, 32'h10, 32'h00, 32'h00, 32'h0);
        run_tick(32'h59, 32'h09, 32'h00, 32'h0, 32'h00, 32'h10, 32'h00, 32'h0);
        run_tick(32'h59, 32'h59, 32'h00, 32'h0, 32'h00, 32'h00, 32'h01, 32'h0);
        run_tick(32'h59, 32'h59, 32'h09, 32'h0, 32'h00, 32'h00, 32'h10, 32'h0);
        run_tick(32'h59, 32'h59, 32'h19, 32'h0, 32'h00, 32'h00, 32'h20, 32'h0);
        // Midnight wrap for each day, Saturday back to Sunday
        for (int d = 0; d < 7; d++)
            run_tick(32'h59, 32'h59, 32'h23, 32'(d), 0, 0, 0, 32'((d + 1) % 7));
        // 12-hour mode: 11 wraps to 00 and flips PM; the weekday steps only on PM to AM
        c1_run = 32'h00000080;
        c1_exp = 32'h000000A2;
        run_tick(32'h59, 32'h59, 32'h11, 32'h3, 0, 0, 0, 32'h3);
        c1_run = 32'h000000A0;
        c1_exp = 32'h00000082;
        run_tick(32'h59, 32'h59, 32'h11, 32'h3, 0, 0, 0, 32'h4);
        // Masked event sets status but keeps the line low
        wr(`RTC_OFS_IMASK, 32'h00000000);
        wr(`RTC_OFS_CTRL1, 32'h000000C0);
        repeat (TICK + 4) @(posedge pclk);
        wr(`RTC_OFS_CTRL1, 32'h00000040);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h00000000);
        wr(`RTC_OFS_IMASK, 32'h00000001);
        // The line follows the mask one edge later
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h00000001);
        rd_chk(`RTC_OFS_ISTAT, 32'h00000001);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, 32'h00000000);
        // Soft reset: set then clear zeroes time, day and both controls
        wr(`RTC_OFS_SEC, 32'h00000042);
        wr(`RTC_OFS_MIN, 32'h00000033);
        wr(`RTC_OFS_HOUR, 32'h00000021);
        wr(`RTC_OFS_WDAY, 32'h00000005);
        wr(`RTC_OFS_CTRL1, 32'h00000050);
        wr(`RTC_OFS_CTRL1, 32'h00000000);
        for (int i = 0; i < 6; i++)
            rd_chk(8'(i * 4), 32'h00000000);
        wrap_up();
    end
endmodule // rtcbcd_tb_top
`default_nettype wire

// >>> rtcbcd_top.sv
// Purpose: Seconds, minutes, hours and weekday BCD counters with APB slave
// Assumes: One 250 MHz clock, one-second tick from an internal divider
// Notes:   One clock, APB registers, sticky per-second interrupt
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtcbcd_params.svh"

module rtcbcd_top #(
    parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES  // Clocks per second
) (
    input  wire logic        pclk,     // APB clock, 250 MHz
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB write
    input  wire logic [7:0]  paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output var  logic [31:0] prdata,   // APB read data
    output var  logic        pready,   // APB ready
    output var  logic        pslverr,  // APB error, unmapped address
    output var  logic        irq       // Level interrupt
);

    // ------------------------------------------------------------
    // BCD step: returns {wrap, next digit}
    // ------------------------------------------------------------
    // Using >= also pulls an illegal preset back to zero
    function automatic logic [4:0] bcd_step(input logic [3:0] d, input logic [3:0] last);
        bcd_step = (d >= last) ? 5'h10 : {1'b0, d + 4'h1};
    endfunction

    rtcbcd_pkg::rtcbcd_time_t sec_q, sec_d, min_q, min_d, hour_q, hour_d;
    rtcbcd_pkg::rtcbcd_day_t  day_q, day_d;
    logic [27:0] div_q;
    logic        start_q, fmt_q, pm_q, srst_q, busy_q, secie_q;
    logic        istat_q, mask_q, irq_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic setup     = psel & ~penable;
    wire logic acc       = psel & penable & pready_q;
    wire logic wr        = acc & pwrite;
    wire logic rd        = acc & ~pwrite;
    wire logic hit_sec   = (paddr == `RTC_OFS_SEC);
    wire logic hit_min   = (paddr == `RTC_OFS_MIN);
    wire logic hit_hour  = (paddr == `RTC_OFS_HOUR);
    wire logic hit_day   = (paddr == `RTC_OFS_WDAY);
    wire logic hit_c1    = (paddr == `RTC_OFS_CTRL1);
    wire logic hit_c2    = (paddr == `RTC_OFS_CTRL2);
    wire logic hit_ist   = (paddr == `RTC_OFS_ISTAT);
    wire logic hit_msk   = (paddr == `RTC_OFS_IMASK);
    wire logic mapped    = hit_sec | hit_min | hit_hour | hit_day | hit_c1 | hit_c2
                           | hit_ist | hit_msk;
    // Soft reset acts on the falling write of the bit, not on the set
    wire logic srst_fire = wr & hit_c1 & srst_q & ~pwdata[`RTC_C1_SRST];

    // ------------------------------------------------------------
    // One-second tick divider
    // ------------------------------------------------------------
    wire logic div_end = (div_q == 28'(TICK_CYCLES - 1));
    wire logic tick    = start_q & div_end;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 28'h0000000;
        else if (srst_fire || !start_q || div_end)
            div_q <= 28'h0000000;
        else
            div_q <= div_q + 28'h0000001;
    end

    // ------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------
    wire logic [4:0] su_n = bcd_step(sec_q[3:0], `RTC_UNITS_LAST);
    wire logic [4:0] st_n = bcd_step({1'b0, sec_q[6:4]}, `RTC_TENS_LAST);
    wire logic [4:0] mu_n = bcd_step(min_q[3:0], `RTC_UNITS_LAST);
    wire logic [4:0] mt_n = bcd_step({1'b0, min_q[6:4]}, `RTC_TENS_LAST);
    wire logic [4:0] hu_n = bcd_step(hour_q[3:0], `RTC_UNITS_LAST);
    wire logic       c_s1 = tick & su_n[4];
    wire logic       c_s2 = c_s1 & st_n[4];
    wire logic       c_m1 = c_s2 & mu_n[4];
    wire logic       c_m2 = c_m1 & mt_n[4];
    // 24-hour mode ends at 23, 12-hour mode at 11 with the PM flag
    wire logic       h_last  = fmt_q ? (hour_q >= `RTC_H24_LAST)
                                     : (hour_q >= `RTC_H12_LAST);
    wire logic       day_adv = c_m2 & h_last & (fmt_q | pm_q);
    wire logic [2:0] ht_inc  = hour_q[6:4] + 3'h1;
    wire rtcbcd_pkg::rtcbcd_time_t hour_step = h_last ? `RTC_RST_TIME
                                  : hu_n[4] ? {ht_inc, 4'h0}
                                  : {hour_q[6:4], hu_n[3:0]};
    wire rtcbcd_pkg::rtcbcd_day_t day_step = (day_q >= `RTC_DAY_LAST) ? `RTC_RST_DAY
                                  : day_q + 3'h1;

    // ------------------------------------------------------------
    // Next time values, software write wins over its own register
    // ------------------------------------------------------------
    assign sec_d  = srst_fire ? `RTC_RST_TIME
                  : (wr & hit_sec) ? pwdata[6:0]
                  : tick ? {(c_s1 ? st_n[2:0] : sec_q[6:4]), su_n[3:0]} : sec_q;
    assign min_d  = srst_fire ? `RTC_RST_TIME
                  : (wr & hit_min) ? pwdata[6:0]
                  : c_s2 ? {(c_m1 ? mt_n[2:0] : min_q[6:4]), mu_n[3:0]} : min_q;
    assign hour_d = srst_fire ? `RTC_RST_TIME
                  : (wr & hit_hour) ? pwdata[6:0]
                  : c_m2 ? hour_step : hour_q;
    // A written 111 is kept as is; it steps to Sunday on the next day carry
    assign day_d  = srst_fire ? `RTC_RST_DAY
                  : (wr & hit_day) ? pwdata[2:0]
                  : day_adv ? day_step : day_q;

    // Time and weekday registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_q  <= `RTC_RST_TIME;
            min_q  <= `RTC_RST_TIME;
            hour_q <= `RTC_RST_TIME;
            day_q  <= `RTC_RST_DAY;
        end
        else
        begin
            sec_q  <= sec_d;
            min_q  <= min_d;
            hour_q <= hour_d;
            day_q  <= day_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Soft reset also drops start, format and PM; the busy flag lags start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_q <= 1'b0;
            fmt_q   <= 1'b0;
            pm_q    <= 1'b0;
            srst_q  <= 1'b0;
            busy_q  <= 1'b0;
            secie_q <= 1'b0;
            mask_q  <= 1'b0;
        end
        else
        begin
            busy_q <= start_q;
            if (srst_fire)
            begin
                start_q <= 1'b0;
                fmt_q   <= 1'b0;
                pm_q    <= 1'b0;
                srst_q  <= 1'b0;
                secie_q <= 1'b0;
            end
            else
            begin
                if (wr & hit_c1)
                begin
                    start_q <= pwdata[`RTC_C1_START];
                    fmt_q   <= pwdata[`RTC_C1_FMT24];
                    srst_q  <= pwdata[`RTC_C1_SRST];
                end
                if (wr & hit_c1)
                    pm_q <= pwdata[`RTC_C1_PM];
                else if (c_m2 & h_last & ~fmt_q)
                    pm_q <= ~pm_q;
                if (wr & hit_c2)
                    secie_q <= pwdata[`RTC_C2_SECIE];
            end
            if (wr & hit_msk)
                mask_q <= pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt status: set wins over the read clear
    // ------------------------------------------------------------
    // Only a bit already returned to software is cleared, so an event
    // landing between setup and access is kept
    wire logic ev_sec  = tick & secie_q;
    wire logic ist_clr = rd & hit_ist & prdata_q[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_q <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            istat_q <= ev_sec | (istat_q & ~ist_clr);
            irq_q   <= istat_q & mask_q;
        end
    end

    // ------------------------------------------------------------
    // Read mux and APB answer
    // ------------------------------------------------------------
    wire logic [7:0] c1_rd = {start_q, fmt_q, pm_q, srst_q, 2'h0, busy_q, 1'b0};
    wire logic [31:0] rd_mux =
          hit_sec  ? {25'h0, sec_q}
        : hit_min  ? {25'h0, min_q}
        : hit_hour ? {25'h0, hour_q}
        : hit_day  ? {29'h0, day_q}
        : hit_c1   ? {24'h0, c1_rd}
        : hit_c2   ? {31'h0, secie_q}
        : hit_ist  ? {31'h0, istat_q}
        : hit_msk  ? {31'h0, mask_q}
        : 32'h00000000;

    // Data and error are loaded in setup so the access phase never waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            pready_q  <= 1'b0;
        end
        else
        begin
            pready_q <= 1'b1;
            if (setup)
            begin
                prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_q <= ~mapped;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_sec_units_wrap: assert property (
        (tick & ~wr & sec_q[3:0] == 4'h9 & sec_q[6:4] < 3'h5)
        |=> (sec_q[3:0] == 4'h0) && (sec_q[6:4] == $past(sec_q[6:4]) + 3'h1))
        else $error("seconds units did not carry");
    chk_sec_minute: assert property (
        (tick & ~wr & sec_q == 7'h59)
        |=> (sec_q == 7'h00) && (min_q != $past(min_q)))
        else $error("sixty seconds did not give a minute");
    chk_min_units_step: assert property (
        (tick & ~wr & sec_q == 7'h59 & min_q[3:0] < 4'h9)
        |=> min_q[3:0] == $past(min_q[3:0]) + 4'h1)
        else $error("minutes units did not step");
    chk_min_tens_carry: assert property (
        (tick & ~wr & sec_q == 7'h59 & min_q[3:0] == 4'h9 & min_q[6:4] < 3'h5)
        |=> (min_q[3:0] == 4'h0) && (min_q[6:4] == $past(min_q[6:4]) + 3'h1))
        else $error("minutes tens did not carry");
    chk_min_hour_carry: assert property (
        (tick & ~wr & sec_q == 7'h59 & min_q == 7'h59)
        |=> (min_q == 7'h00) && (hour_q != $past(hour_q)))
        else $error("sixty minutes did not give an hour");
    chk_hour_units_carry: assert property (
        (c_m2 & ~wr & hour_q == 7'h09)
        |=> hour_q == 7'h10)
        else $error("hours units did not carry");
    chk_hour_day_wrap: assert property (
        (c_m2 & ~wr & fmt_q & hour_q == 7'h23)
        |=> (hour_q == 7'h00) && (day_q != $past(day_q)))
        else $error("hour 23 did not wrap with a day step");
    chk_day_saturday: assert property (
        (day_adv & ~wr & day_q == 3'h6) |=> day_q == 3'h0)
        else $error("saturday did not wrap to sunday");
    chk_h12_wrap: assert property (
        (c_m2 & ~wr & ~fmt_q & hour_q == 7'h11)
        |=> (hour_q == 7'h00) && (pm_q != $past(pm_q)))
        else $error("12-hour mode did not wrap at 11");
    chk_write_store: assert property (
        (wr & hit_min) |=> min_q == $past(pwdata[6:0]))
        else $error("minutes write not stored");
    chk_bit7_zero: assert property (
        (setup & ~pwrite & (hit_sec | hit_min | hit_hour)) |=> prdata_q[31:7] == 25'h0)
        else $error("upper count bits not zero");
    chk_soft_reset: assert property (
        srst_fire |=> (sec_q == 7'h00) && (min_q == 7'h00) && (hour_q == 7'h00)
                      && (day_q == 3'h0) && !secie_q && !start_q)
        else $error("soft reset did not clear counters");
    chk_sec_irq: assert property (
        (tick & secie_q & mask_q) |=> istat_q ##1 irq_q)
        else $error("per-second interrupt missing");

    cov_day_roll:   cover property (day_adv & fmt_q);
    cov_soft_reset: cover property (srst_fire);
    cov_irq_read:   cover property (ist_clr);
    cov_bad_addr:   cover property (setup & ~mapped);

endmodule // rtcbcd_top
`default_nettype wire
